// >>> core/rsem_cnt_bank.sv
// Bank of saturating 8-bit single-bit error counters with per-counter clear.
`timescale 1ns/1ps
module rsem_cnt_bank
   import rsem_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [RSEM_NUM_CNT-1:0] inc,
   input wire logic [RSEM_NUM_CNT-1:0] clr,
   output logic [RSEM_NUM_CNT-1:0][7:0] cnt
);
   typedef struct packed {
      logic [RSEM_NUM_CNT-1:0][7:0] cnt_r;
   } rsem_bank_t;

   rsem_bank_t st_r;
   rsem_bank_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      for (int i = 0; i < RSEM_NUM_CNT; i++) begin
         // An error seen in the clearing cycle still counts as the first one.
         if (clr[i]) begin
            st_nxt.cnt_r[i] = {7'h00, inc[i]};
         end else if (inc[i] && st_r.cnt_r[i] != RSEM_CNT_MAX) begin
            st_nxt.cnt_r[i] = st_r.cnt_r[i] + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cnt = st_r.cnt_r;
endmodule : rsem_cnt_bank

// >>> core/rsem_pkg.sv
// Constants and layouts of the RAM soft error monitor.
package rsem_pkg;
   localparam logic [11:0] RSEM_OFS_PAY0 = 12'h800;
   localparam logic [11:0] RSEM_OFS_PAY1 = 12'h804;
   localparam logic [11:0] RSEM_OFS_PAY2 = 12'h808;
   localparam logic [11:0] RSEM_OFS_HDR = 12'h810;
   localparam logic [11:0] RSEM_OFS_PLL_A = 12'h820;
   localparam logic [11:0] RSEM_OFS_PLL_B = 12'h824;
   localparam logic [11:0] RSEM_OFS_MISC = 12'h828;
   localparam logic [11:0] RSEM_OFS_INJ = 12'h82C;
   localparam logic [31:0] RSEM_RST_WORD = 32'h0000_0000;
   localparam logic [7:0] RSEM_CNT_MAX = 8'hFF;
   localparam int RSEM_NUM_CNT = 24;
   localparam int RSEM_NUM_RAM = 5;
   localparam int RSEM_NUM_STN = 3;
   // Counter indices inside the counter bank.
   localparam int RSEM_IX_PAY = 0;
   localparam int RSEM_IX_HDR = 12;
   localparam int RSEM_IX_PLL = 15;
   localparam int RSEM_IX_LL1 = 18;
   localparam int RSEM_IX_LL2 = 19;
   localparam int RSEM_IX_DQD = 20;
   localparam int RSEM_IX_LL0 = 21;
   localparam int RSEM_IX_SQ = 22;
   localparam int RSEM_IX_RTY = 23;
   // Injectable RAMs, in the order of their bit triplets in the injection word.
   localparam int RSEM_RAM_DQD = 0;
   localparam int RSEM_RAM_LL0 = 1;
   localparam int RSEM_RAM_RTY = 2;
   localparam int RSEM_RAM_LL1 = 3;
   localparam int RSEM_RAM_LL2 = 4;
   localparam int RSEM_INJ_W = 3;
   localparam int RSEM_INJ_ONE_POS = 0;
   localparam int RSEM_INJ_TWO_POS = 1;
   localparam int RSEM_INJ_SEL_POS = 2;
   localparam int RSEM_CLR_PAY_POS = 20;
   localparam int RSEM_CLR_HDR_POS = 24;
   localparam int RSEM_STN_POS = 29;
   localparam logic [2:0] RSEM_STN0 = 3'h0;
   localparam logic [2:0] RSEM_STN2 = 3'h2;
endpackage : rsem_pkg

// >>> core/rsem_top.sv
// RAM soft error counters, one-shot error injection and counter clears selected per station group (0 to 2).
`timescale 1ns/1ps
module rsem_top
   import rsem_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire logic [11:0] CFG_ADDR,
   input wire logic [31:0] CFG_WDATA,
   output logic [31:0] CFG_RDATA,
   output logic CFG_RVALID,
   input wire logic [11:0] PAY_SBE,
   input wire logic [2:0] HDR_SBE,
   input wire logic [2:0] PLL_SBE,
   input wire logic DQD_SBE,
   input wire logic [2:0] DQLL_SBE,
   input wire logic SQLL_SBE,
   input wire logic RTY_SBE,
   input wire logic [4:0] RAM_WR,
   output logic [4:0] INJ_ONE,
   output logic [4:0] INJ_TWO,
   output logic [4:0] INJ_DATA_SEL
);
   typedef struct packed {
      logic [RSEM_NUM_RAM-1:0] one_r;
      logic [RSEM_NUM_RAM-1:0] two_r;
      logic [RSEM_NUM_RAM-1:0] sel_r;
      logic [31:0] rdata_r;
      logic rvalid_r;
   } rsem_state_t;

   rsem_state_t st_r;
   rsem_state_t st_nxt;
   logic [RSEM_NUM_CNT-1:0] inc;
   logic [RSEM_NUM_CNT-1:0] clr;
   logic [RSEM_NUM_CNT-1:0][7:0] cnt;
   logic inj_wr;
   logic [2:0] stn;

   function automatic logic [31:0] pack4(input logic [7:0] b3, input logic [7:0] b2,
                                         input logic [7:0] b1, input logic [7:0] b0);
      pack4 = {b3, b2, b1, b0};
   endfunction : pack4

   // Position of one bit of a RAM's triplet in the injection word.
   function automatic int inj_bit(input int r, input int pos);
      inj_bit = r * RSEM_INJ_W + pos;
   endfunction : inj_bit

   always_comb begin
      inc = '0;
      inc[RSEM_IX_PAY +: 12] = PAY_SBE;
      inc[RSEM_IX_HDR +: 3] = HDR_SBE;
      inc[RSEM_IX_PLL +: 3] = PLL_SBE;
      inc[RSEM_IX_DQD] = DQD_SBE;
      inc[RSEM_IX_LL0] = DQLL_SBE[0];
      inc[RSEM_IX_LL1] = DQLL_SBE[1];
      inc[RSEM_IX_LL2] = DQLL_SBE[2];
      inc[RSEM_IX_SQ] = SQLL_SBE;
      inc[RSEM_IX_RTY] = RTY_SBE;
   end

   assign inj_wr = CFG_WR && CFG_ADDR == RSEM_OFS_INJ;
   assign stn = CFG_WDATA[RSEM_STN_POS +: 3];

   always_comb begin
      clr = '0;
      if (inj_wr && stn <= RSEM_STN2) begin
         for (int s = 0; s < RSEM_NUM_STN; s++) begin
            if (stn == 3'(s)) begin
               for (int l = 0; l < 4; l++) begin
                  clr[RSEM_IX_PAY + s * 4 + l] = CFG_WDATA[RSEM_CLR_PAY_POS + l];
               end
               clr[RSEM_IX_HDR + s] = CFG_WDATA[RSEM_CLR_HDR_POS];
            end
         end
      end
   end

   rsem_cnt_bank u_bank (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .inc(inc),
      .clr(clr),
      .cnt(cnt)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid_r = CFG_RD;
      for (int r = 0; r < RSEM_NUM_RAM; r++) begin
         if (RAM_WR[r]) begin
            st_nxt.one_r[r] = 1'b0;
            st_nxt.two_r[r] = 1'b0;
         end
      end
      if (inj_wr) begin
         for (int r = 0; r < RSEM_NUM_RAM; r++) begin
            if (CFG_WDATA[inj_bit(r, RSEM_INJ_ONE_POS)]) begin
               st_nxt.one_r[r] = 1'b1;
            end
            if (CFG_WDATA[inj_bit(r, RSEM_INJ_TWO_POS)]) begin
               st_nxt.two_r[r] = 1'b1;
            end
            st_nxt.sel_r[r] = CFG_WDATA[inj_bit(r, RSEM_INJ_SEL_POS)];
         end
      end
      st_nxt.rdata_r = RSEM_RST_WORD;
      if (CFG_RD) begin
         unique case (CFG_ADDR)
            RSEM_OFS_PAY0: st_nxt.rdata_r = pack4(cnt[3], cnt[2], cnt[1], cnt[0]);
            RSEM_OFS_PAY1: st_nxt.rdata_r = pack4(cnt[7], cnt[6], cnt[5], cnt[4]);
            RSEM_OFS_PAY2: st_nxt.rdata_r = pack4(cnt[11], cnt[10], cnt[9], cnt[8]);
            RSEM_OFS_HDR: st_nxt.rdata_r = pack4(8'h00, cnt[14], cnt[13], cnt[12]);
            RSEM_OFS_PLL_A: st_nxt.rdata_r = pack4(8'h00, cnt[17], cnt[16], cnt[15]);
            RSEM_OFS_PLL_B: st_nxt.rdata_r = pack4(cnt[RSEM_IX_LL2], cnt[RSEM_IX_LL1], 8'h00, 8'h00);
            RSEM_OFS_MISC: st_nxt.rdata_r = pack4(cnt[RSEM_IX_RTY], cnt[RSEM_IX_SQ],
                                                  cnt[RSEM_IX_LL0], cnt[RSEM_IX_DQD]);
            RSEM_OFS_INJ: begin
               for (int r = 0; r < RSEM_NUM_RAM; r++) begin
                  st_nxt.rdata_r[inj_bit(r, RSEM_INJ_ONE_POS)] = st_r.one_r[r];
                  st_nxt.rdata_r[inj_bit(r, RSEM_INJ_TWO_POS)] = st_r.two_r[r];
                  st_nxt.rdata_r[inj_bit(r, RSEM_INJ_SEL_POS)] = st_r.sel_r[r];
               end
            end
            default: st_nxt.rdata_r = RSEM_RST_WORD;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // one or two flipped bits per armed write
   assign INJ_ONE = st_r.one_r;
   assign INJ_TWO = st_r.two_r;
   assign INJ_DATA_SEL = st_r.sel_r;
   // one registered copy drives the read data port
   assign CFG_RDATA = st_r.rdata_r;
   assign CFG_RVALID = st_r.rvalid_r;
endmodule : rsem_top

// >>> verif/rsem_properties.sv
// Checker of the register port and injection outputs of the soft error monitor.
`timescale 1ns/1ps
module rsem_properties
   import rsem_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire logic [11:0] CFG_ADDR,
   input wire logic [31:0] CFG_WDATA,
   input wire logic [31:0] CFG_RDATA,
   input wire logic CFG_RVALID,
   input wire logic [4:0] RAM_WR,
   input wire logic [4:0] INJ_ONE,
   input wire logic [4:0] INJ_TWO,
   input wire logic [4:0] INJ_DATA_SEL
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   logic iw;
   logic [4:0] one_w, two_w, sel_w;
   assign iw = CFG_WR && CFG_ADDR == RSEM_OFS_INJ;
   assign one_w = {CFG_WDATA[12], CFG_WDATA[9], CFG_WDATA[6], CFG_WDATA[3], CFG_WDATA[0]};
   assign two_w = {CFG_WDATA[13], CFG_WDATA[10], CFG_WDATA[7], CFG_WDATA[4], CFG_WDATA[1]};
   assign sel_w = {CFG_WDATA[14], CFG_WDATA[11], CFG_WDATA[8], CFG_WDATA[5], CFG_WDATA[2]};
   property p_one; iw |=> (INJ_ONE & $past(one_w)) == $past(one_w); endproperty
   a_one: assert property (p_one) else $error("one-bit trigger not armed");
   property p_two; iw |=> (INJ_TWO & $past(two_w)) == $past(two_w); endproperty
   a_two: assert property (p_two) else $error("two-bit trigger not armed");
   property p_sel; iw |=> INJ_DATA_SEL == $past(sel_w); endproperty
   a_sel: assert property (p_sel) else $error("field select not stored");
   property p_shot; RAM_WR[0] && INJ_ONE[0] && !(iw && CFG_WDATA[0]) |=> !INJ_ONE[0]; endproperty
   a_shot: assert property (p_shot) else $error("injection not one-shot");
   property p_hold; INJ_TWO[2] && !RAM_WR[2] |=> INJ_TWO[2]; endproperty
   a_hold: assert property (p_hold) else $error("armed injection lost");
   property p_pa; CFG_RD && CFG_ADDR == RSEM_OFS_PLL_A |=> CFG_RVALID && CFG_RDATA[31:24] == 8'h00; endproperty
   a_pa: assert property (p_pa) else $error("pll top byte not zero");
   property p_pb; CFG_RD && CFG_ADDR == RSEM_OFS_PLL_B |=> CFG_RVALID && CFG_RDATA[15:0] == 16'h0000; endproperty
   a_pb: assert property (p_pb) else $error("pll b low half not zero");
   property p_ir; CFG_RD && CFG_ADDR == RSEM_OFS_INJ |=> CFG_RVALID && CFG_RDATA[31:15] == 17'h00000; endproperty
   a_ir: assert property (p_ir) else $error("clear or selector bits read back");
   c_arm: cover property (iw && CFG_WDATA[0]);
   c_use: cover property (RAM_WR[0] && INJ_ONE[0]);
   c_rd: cover property (CFG_RD && CFG_ADDR == RSEM_OFS_MISC);
endmodule : rsem_properties
bind rsem_top rsem_properties u_rsem_properties (.SYS_CLK, .RST_N, .CFG_WR, .CFG_RD, .CFG_ADDR,
   .CFG_WDATA, .CFG_RDATA, .CFG_RVALID, .RAM_WR, .INJ_ONE, .INJ_TWO, .INJ_DATA_SEL);

// >>> verif/testbench.sv
// Self-checking testbench of the RAM soft error monitor.
`timescale 1ns/1ps
module testbench
   import rsem_pkg::*;
;
   logic SYS_CLK, RST_N, CFG_WR, CFG_RD, CFG_RVALID, DQD_SBE, SQLL_SBE, RTY_SBE;
   logic [11:0] CFG_ADDR, PAY_SBE;
   logic [31:0] CFG_WDATA, CFG_RDATA;
   logic [2:0] HDR_SBE, PLL_SBE, DQLL_SBE;
   logic [4:0] RAM_WR, INJ_ONE, INJ_TWO, INJ_DATA_SEL;
   int errors, total_checks;
   rsem_top u_rsem_top (.SYS_CLK, .RST_N, .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_WDATA, .CFG_RDATA,
      .CFG_RVALID, .PAY_SBE, .HDR_SBE, .PLL_SBE, .DQD_SBE, .DQLL_SBE, .SQLL_SBE, .RTY_SBE,
      .RAM_WR, .INJ_ONE, .INJ_TWO, .INJ_DATA_SEL);
   initial begin
      SYS_CLK = 1'b0;
      forever #5 SYS_CLK = ~SYS_CLK;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      CFG_WR <= 1'b1;
      CFG_ADDR <= a;
      CFG_WDATA <= d;
      @(posedge SYS_CLK);
      CFG_WR <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge SYS_CLK);
      CFG_RD <= 1'b1;
      CFG_ADDR <= a;
      @(posedge SYS_CLK);
      CFG_RD <= 1'b0;
      #1;
      check(32'(CFG_RVALID), 32'h1, "rvalid");
      check(CFG_RDATA, exp, $sformatf("read %h", a));
   endtask : rd
   task automatic ram_wr(input logic [4:0] m, input logic [4:0] one, input logic [4:0] two);
      @(posedge SYS_CLK);
      RAM_WR <= m;
      @(posedge SYS_CLK);
      RAM_WR <= 5'h00;
      #1;
      check(32'(INJ_ONE), 32'(one), "inj one");
      check(32'(INJ_TWO), 32'(two), "inj two");
   endtask : ram_wr
   task automatic t_reset();
      for (int a = 'h800; a <= 'h830; a += 4) rd(12'(a), RSEM_RST_WORD);
   endtask : t_reset
   task automatic t_count();
      for (int i = 0; i < 6; i++) begin
         @(posedge SYS_CLK);
         PLL_SBE <= {i < 3, i < 2, i < 1};
         DQLL_SBE <= {i < 3, i < 2, i < 1};
         PAY_SBE <= {12{i < 2}};
         HDR_SBE <= {3{i < 3}};
         DQD_SBE <= i < 4;
         SQLL_SBE <= i < 2;
         RTY_SBE <= i < 5;
      end
      wr(RSEM_OFS_PLL_A, 32'hFFFF_FFFF);
      rd(RSEM_OFS_PLL_A, 32'h0003_0201);
      rd(RSEM_OFS_PLL_B, 32'h0302_0000);
      rd(RSEM_OFS_MISC, 32'h0502_0104);
      rd(RSEM_OFS_PAY1, 32'h0202_0202);
      rd(RSEM_OFS_HDR, 32'h0003_0303);
      @(posedge SYS_CLK);
      SQLL_SBE <= 1'b1;
      repeat (300) @(posedge SYS_CLK);
      SQLL_SBE <= 1'b0;
      rd(RSEM_OFS_MISC, 32'h05FF_0104);
   endtask : t_count
   task automatic t_clear();
      wr(RSEM_OFS_INJ, 32'h21F0_0000);
      rd(RSEM_OFS_PAY1, 32'h0000_0000);
      rd(RSEM_OFS_PAY0, 32'h0202_0202);
      rd(RSEM_OFS_HDR, 32'h0003_0003);
      wr(RSEM_OFS_INJ, 32'h6150_0000);
      rd(RSEM_OFS_PAY2, 32'h0202_0202);
      wr(RSEM_OFS_INJ, 32'h5E50_0000);
      rd(RSEM_OFS_PAY2, 32'h0200_0200);
      rd(RSEM_OFS_HDR, 32'h0003_0003);
      @(posedge SYS_CLK);
      CFG_WR <= 1'b1;
      CFG_ADDR <= RSEM_OFS_INJ;
      CFG_WDATA <= 32'h0110_0000;
      PAY_SBE <= 12'h001;
      HDR_SBE <= 3'h1;
      @(posedge SYS_CLK);
      CFG_WR <= 1'b0;
      PAY_SBE <= 12'h000;
      HDR_SBE <= 3'h0;
      rd(RSEM_OFS_PAY0, 32'h0202_0201);
      rd(RSEM_OFS_HDR, 32'h0003_0001);
      rd(RSEM_OFS_INJ, 32'h0000_0000);
   endtask : t_clear
   task automatic t_inject();
      wr(RSEM_OFS_INJ, 32'h0000_7FFF);
      check(32'(INJ_ONE), 32'h1F, "inj one");
      check(32'(INJ_TWO), 32'h1F, "inj two");
      check(32'(INJ_DATA_SEL), 32'h1F, "inj sel");
      rd(RSEM_OFS_INJ, 32'h0000_7FFF);
      ram_wr(5'h01, 5'h1E, 5'h1E);
      wr(RSEM_OFS_INJ, 32'h0000_0000);
      check(32'(INJ_DATA_SEL), 32'h00, "inj sel");
      rd(RSEM_OFS_INJ, 32'h0000_36D8);
      ram_wr(5'h1F, 5'h00, 5'h00);
      ram_wr(5'h1F, 5'h00, 5'h00);
   endtask : t_inject
   task automatic results();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   initial begin
      #100000;
      errors++;
      results();
   end
   initial begin
      {CFG_WR, CFG_RD, CFG_ADDR, CFG_WDATA, PAY_SBE, HDR_SBE, PLL_SBE} = '0;
      {DQD_SBE, DQLL_SBE, SQLL_SBE, RTY_SBE, RAM_WR} = '0;
      RST_N = 1'b0;
      repeat (10) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      t_reset();
      t_count();
      t_clear();
      t_inject();
      results();
   end
endmodule : testbench
